// file: verilog/rmp_pkg.sv
// Constants, types and helpers of the reading math post-processor
package rmp_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam int unsigned AW = 8;
  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_DB_REF = 8'h04;
  localparam logic [AW-1:0] A_DBM_REF = 8'h08;
  localparam logic [AW-1:0] A_LIM_LO = 8'h0C;
  localparam logic [AW-1:0] A_LIM_HI = 8'h10;
  localparam logic [AW-1:0] A_NULL = 8'h14;
  localparam logic [AW-1:0] A_PRESET = 8'h18;
  localparam logic [AW-1:0] A_STATUS = 8'h1C;
  localparam logic [AW-1:0] A_COUNT = 8'h20;
  localparam logic [AW-1:0] A_MAX = 8'h24;
  localparam logic [AW-1:0] A_MIN = 8'h28;
  localparam logic [AW-1:0] A_MEAN = 8'h2C;
  localparam logic [AW-1:0] A_RESULT = 8'h30;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_SEL = 4;
  localparam int unsigned SEL_W = 3;
  // Preset bits: lower min/max, upper min/max, null min/max, dB min/max, dBm min/max
  localparam int unsigned PR_LO = 0;
  localparam int unsigned PR_HI = 2;
  localparam int unsigned PR_NULL = 4;
  localparam int unsigned PR_DB = 6;
  localparam int unsigned PR_DBM = 8;
  localparam int unsigned STS_CONFLICT = 0;
  localparam int unsigned STS_RANGE = 1;
  localparam int unsigned STS_FAIL = 2;

  typedef enum logic [2:0] {
    SEL_AVER = 3'h0,
    SEL_DB = 3'h1,
    SEL_DBM = 3'h2,
    SEL_LIM = 3'h3,
    SEL_NULL = 3'h4
  } rmp_sel_t;

  typedef enum logic [3:0] {
    FN_DCV = 4'h0, FN_ACV = 4'h1, FN_DCI = 4'h2, FN_ACI = 4'h3, FN_OHM2 = 4'h4,
    FN_OHM4 = 4'h5, FN_FREQ = 4'h6, FN_PER = 4'h7, FN_RATIO = 4'h8
  } rmp_func_t;

  // ----------------------------------------------------------------
  // Arithmetic constants (readings Q16.16, decibels Q24.8)
  // ----------------------------------------------------------------
  localparam int Q_FRAC = 32'h0000_0010;
  localparam int LOG_ONE = 32'h0000_0100;
  localparam int K20 = 32'h0000_0605;
  localparam int K10 = 32'h0000_0303;
  localparam int MW_OFS = 32'h0000_1E00;
  localparam logic signed [31:0] DB_BOUND = 32'sh0000_C800;
  localparam logic [39:0] LIM_PCT = 40'h00_0000_0078;
  localparam logic [39:0] PCT_DIV = 40'h00_0000_0064;
  localparam logic [15:0] DBM_DEF = 16'h0258;
  localparam logic [15:0] DBM_MIN = 16'h0032;
  localparam logic [15:0] DBM_MAX = 16'h1F40;
  localparam int unsigned N_OHMS = 17;
  localparam logic [15:0] DBM_OHMS [N_OHMS] = '{
    16'h0032, 16'h004B, 16'h005D, 16'h006E, 16'h007C, 16'h007D, 16'h0087, 16'h0096,
    16'h00FA, 16'h012C, 16'h01F4, 16'h0258, 16'h0320, 16'h0384, 16'h03E8, 16'h04B0,
    16'h1F40};

  typedef struct packed {
    logic signed [31:0] value;
    rmp_sel_t sel;
    logic math_on;
    logic lim_fail;
  } rmp_res_t;

  function automatic logic ohms_ok(input logic [15:0] r);
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < N_OHMS; i++) ok = ok | (DBM_OHMS[i] == r);
    return ok;
  endfunction : ohms_ok

  function automatic logic allowed(input rmp_sel_t s, input rmp_func_t f);
    logic ac_dc_v;
    ac_dc_v = (f == FN_DCV) || (f == FN_ACV);
    if (s == SEL_DB || s == SEL_DBM) return ac_dc_v;
    if (s == SEL_NULL) return f != FN_RATIO;
    return 1'b1;
  endfunction : allowed

  // Base-2 logarithm, Q8; linear mantissa keeps it to one shifter
  function automatic int log2q8(input logic [31:0] v);
    int p;
    logic [31:0] m;
    p = 0;
    for (int i = 0; i < 32; i++) if (v[i]) p = i;
    m = v << (31 - p);
    return p * LOG_ONE + int'(m[30:23]);
  endfunction : log2q8

endpackage : rmp_pkg

// file: verilog/rmp_math_post.sv
// Reading math post-processor: APB registers, math datapath and averaging
module rmp_math_post #(
  parameter int unsigned SUM_W = 48
) (
  // Clock and resets
  input wire logic CLK,
  input wire logic RESET,
  input wire logic NV_INIT,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [rmp_pkg::AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // Measurement engine
  input wire rmp_pkg::rmp_func_t MEAS_FUNC,
  input wire logic [31:0] RANGE_MAX,
  input wire logic RDG_VALID,
  input wire logic signed [31:0] RDG_VALUE,
  output logic RDG_READY,
  // Results
  output logic RES_VALID,
  output rmp_pkg::rmp_res_t RES
);

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DIV} rmp_state_t;
  localparam int RES_LAT_MAX = SUM_W + 3;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic en_q;
  rmp_pkg::rmp_sel_t sel_q;
  rmp_pkg::rmp_func_t fn_q;
  logic conflict_q, range_q;
  logic signed [31:0] db_ref_q, lim_lo_q, lim_hi_q, null_q;
  logic [15:0] ohm_q;
  logic [31:0] count_q;
  logic signed [SUM_W-1:0] sum_q;
  logic signed [31:0] max_q, min_q, mean_q, rdg_q;
  logic avg_on, avg_on_q, avg_start, accept;
  rmp_state_t state_q;
  logic [32:0] rem_q, rem_sh;
  logic [SUM_W-1:0] quo_q, quo_nxt;
  logic [31:0] dsr_q;
  logic neg_q;
  logic [7:0] step_q;
  logic res_vld_q;
  rmp_pkg::rmp_res_t res_q;
  logic [31:0] prdata_q, rd_val;
  logic pslverr_q;
  logic wr, wr_ctrl, wr_sts, wr_val;
  rmp_pkg::rmp_sel_t wsel;
  logic wsel_ok;
  logic [39:0] bprod;
  logic signed [32:0] bound, wval;
  logic w_in_rng, w_in_db;
  logic signed [31:0] math_val;
  logic lim_fail;
  longint mean_err;

  // ----------------------------------------------------------------
  // APB slave: data latched in setup, no wait states
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [rmp_pkg::AW-1:0] a);
    return (a[1:0] == 2'b00) && (a <= rmp_pkg::A_RESULT);
  endfunction : addr_hit

  assign PREADY = PSEL & PENABLE;
  assign PRDATA = prdata_q;
  assign PSLVERR = pslverr_q & PREADY;
  assign wr = PSEL & PENABLE & PWRITE & addr_hit(PADDR);
  assign wr_ctrl = wr && (PADDR == rmp_pkg::A_CTRL);
  assign wr_sts = wr && (PADDR == rmp_pkg::A_STATUS);
  // Values only land while math is on; earlier writes are dropped
  assign wr_val = wr && en_q;
  assign wsel = rmp_pkg::rmp_sel_t'(PWDATA[rmp_pkg::CTRL_SEL +: rmp_pkg::SEL_W]);
  assign wsel_ok = PWDATA[rmp_pkg::CTRL_SEL +: rmp_pkg::SEL_W] <= rmp_pkg::SEL_NULL;

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (PADDR)
      rmp_pkg::A_CTRL: begin
        rd_val[rmp_pkg::CTRL_EN] = en_q;
        rd_val[rmp_pkg::CTRL_SEL +: rmp_pkg::SEL_W] = sel_q;
      end
      rmp_pkg::A_DB_REF: rd_val = db_ref_q;
      rmp_pkg::A_DBM_REF: rd_val = {16'h0000, ohm_q};
      rmp_pkg::A_LIM_LO: rd_val = lim_lo_q;
      rmp_pkg::A_LIM_HI: rd_val = lim_hi_q;
      rmp_pkg::A_NULL: rd_val = null_q;
      rmp_pkg::A_STATUS: begin
        rd_val[rmp_pkg::STS_CONFLICT] = conflict_q;
        rd_val[rmp_pkg::STS_RANGE] = range_q;
        rd_val[rmp_pkg::STS_FAIL] = res_q.lim_fail;
      end
      rmp_pkg::A_COUNT: rd_val = count_q;
      rmp_pkg::A_MAX: rd_val = max_q;
      rmp_pkg::A_MIN: rd_val = min_q;
      rmp_pkg::A_MEAN: rd_val = mean_q;
      rmp_pkg::A_RESULT: rd_val = res_q.value;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      prdata_q <= rd_val;
      pslverr_q <= !addr_hit(PADDR);
    end
  end

  // ----------------------------------------------------------------
  // Selection, enable and conflict
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      en_q <= 1'b0;
      sel_q <= rmp_pkg::SEL_NULL;
      fn_q <= rmp_pkg::FN_DCV;
      conflict_q <= 1'b0;
    end else begin
      fn_q <= MEAS_FUNC;
      if (wr_sts && PWDATA[rmp_pkg::STS_CONFLICT]) conflict_q <= 1'b0;
      if (wr_ctrl) begin
        if (wsel_ok) sel_q <= wsel;
        en_q <= PWDATA[rmp_pkg::CTRL_EN];
        if (PWDATA[rmp_pkg::CTRL_EN] && !rmp_pkg::allowed(wsel_ok ? wsel : sel_q, fn_q)) begin
          en_q <= 1'b0;
          if (en_q) conflict_q <= 1'b1;
        end
      end
      // Function moved under an enabled operation: set wins over clear
      if (en_q && MEAS_FUNC != fn_q && !rmp_pkg::allowed(sel_q, MEAS_FUNC)) begin
        en_q <= 1'b0;
        conflict_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Volatile values with range checks
  // ----------------------------------------------------------------
  assign bprod = 40'(RANGE_MAX) * rmp_pkg::LIM_PCT;
  assign bound = 33'(bprod / rmp_pkg::PCT_DIV);
  assign wval = 33'(signed'(PWDATA));
  assign w_in_rng = (wval >= -bound) && (wval <= bound);
  assign w_in_db = (signed'(PWDATA) >= -rmp_pkg::DB_BOUND) &&
                   (signed'(PWDATA) <= rmp_pkg::DB_BOUND);

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      db_ref_q <= 32'sh0000_0000;
      lim_lo_q <= 32'sh0000_0000;
      lim_hi_q <= 32'sh0000_0000;
      null_q <= 32'sh0000_0000;
      range_q <= 1'b0;
    end else begin
      if (wr_sts && PWDATA[rmp_pkg::STS_RANGE]) range_q <= 1'b0;
      if (wr_val) begin
        unique case (PADDR)
          rmp_pkg::A_DB_REF: if (w_in_db) db_ref_q <= PWDATA; else range_q <= 1'b1;
          rmp_pkg::A_LIM_LO: if (w_in_rng) lim_lo_q <= PWDATA; else range_q <= 1'b1;
          rmp_pkg::A_LIM_HI: if (w_in_rng) lim_hi_q <= PWDATA; else range_q <= 1'b1;
          rmp_pkg::A_NULL: if (w_in_rng) null_q <= PWDATA; else range_q <= 1'b1;
          rmp_pkg::A_PRESET: begin
            // Min preset bit wins over max when both are set
            if (PWDATA[rmp_pkg::PR_LO + 1]) lim_lo_q <= 32'(bound);
            if (PWDATA[rmp_pkg::PR_LO]) lim_lo_q <= 32'(-bound);
            if (PWDATA[rmp_pkg::PR_HI + 1]) lim_hi_q <= 32'(bound);
            if (PWDATA[rmp_pkg::PR_HI]) lim_hi_q <= 32'(-bound);
            if (PWDATA[rmp_pkg::PR_NULL + 1]) null_q <= 32'(bound);
            if (PWDATA[rmp_pkg::PR_NULL]) null_q <= 32'(-bound);
            if (PWDATA[rmp_pkg::PR_DB + 1]) db_ref_q <= rmp_pkg::DB_BOUND;
            if (PWDATA[rmp_pkg::PR_DB]) db_ref_q <= -rmp_pkg::DB_BOUND;
          end
          default: ;
        endcase
      end
    end
  end

  // Resistance sits outside the interface reset; only NV_INIT restores it
  always_ff @(posedge CLK or posedge NV_INIT) begin
    if (NV_INIT) begin
      ohm_q <= rmp_pkg::DBM_DEF;
    end else if (wr_val && PADDR == rmp_pkg::A_DBM_REF) begin
      if (rmp_pkg::ohms_ok(PWDATA[15:0]) && PWDATA[31:16] == 16'h0000) ohm_q <= PWDATA[15:0];
    end else if (wr_val && PADDR == rmp_pkg::A_PRESET) begin
      if (PWDATA[rmp_pkg::PR_DBM + 1]) ohm_q <= rmp_pkg::DBM_MAX;
      if (PWDATA[rmp_pkg::PR_DBM]) ohm_q <= rmp_pkg::DBM_MIN;
    end
  end

  // ----------------------------------------------------------------
  // Running statistics
  // ----------------------------------------------------------------
  assign avg_on = en_q && (sel_q == rmp_pkg::SEL_AVER);
  assign avg_start = avg_on && !avg_on_q;
  assign accept = RDG_VALID && RDG_READY;
  assign RDG_READY = (state_q == ST_IDLE);

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      avg_on_q <= 1'b0;
      count_q <= 32'h0000_0000;
      sum_q <= '0;
      max_q <= 32'sh0000_0000;
      min_q <= 32'sh0000_0000;
    end else begin
      avg_on_q <= avg_on;
      if (avg_start) begin
        count_q <= 32'h0000_0000;
        sum_q <= '0;
        max_q <= 32'sh0000_0000;
        min_q <= 32'sh0000_0000;
      end else if (accept && avg_on) begin
        count_q <= count_q + 32'h0000_0001;
        sum_q <= sum_q + SUM_W'(RDG_VALUE);
        if (count_q == 32'h0000_0000 || RDG_VALUE > max_q) max_q <= RDG_VALUE;
        if (count_q == 32'h0000_0000 || RDG_VALUE < min_q) min_q <= RDG_VALUE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-reading math
  // ----------------------------------------------------------------
  always_comb begin
    int lv;
    int power_decibel_mode;
    lv = rmp_pkg::log2q8(rdg_q[31] ? 32'(-rdg_q) : 32'(rdg_q)) - rmp_pkg::Q_FRAC * rmp_pkg::LOG_ONE;
    // Volts squared over ohms, scaled to milliwatts; log2 to decibels by constants
    power_decibel_mode = ((rmp_pkg::K20 * lv) >>> 8) - ((rmp_pkg::K10 * rmp_pkg::log2q8(32'(ohm_q))) >>> 8)
          + rmp_pkg::MW_OFS;
    math_val = rdg_q;
    unique case (sel_q)
      rmp_pkg::SEL_NULL: math_val = rdg_q - null_q;
      rmp_pkg::SEL_DB: math_val = 32'(power_decibel_mode) - db_ref_q;
      rmp_pkg::SEL_DBM: math_val = 32'(power_decibel_mode);
      rmp_pkg::SEL_LIM: math_val = rdg_q;
      rmp_pkg::SEL_AVER: math_val = rdg_q;
    endcase
    if (!en_q) math_val = rdg_q;
    lim_fail = en_q && sel_q == rmp_pkg::SEL_LIM &&
               (rdg_q < lim_lo_q || rdg_q > lim_hi_q);
  end

  // ----------------------------------------------------------------
  // Sequencer and serial divider for the mean
  // ----------------------------------------------------------------
  assign rem_sh = {rem_q[31:0], quo_q[SUM_W-1]};
  assign quo_nxt = {quo_q[SUM_W-2:0], rem_sh >= {1'b0, dsr_q}};

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_q <= ST_IDLE;
      rdg_q <= 32'sh0000_0000;
      rem_q <= '0;
      quo_q <= '0;
      dsr_q <= 32'h0000_0000;
      neg_q <= 1'b0;
      step_q <= 8'h00;
      mean_q <= 32'sh0000_0000;
      res_q <= '0;
      res_vld_q <= 1'b0;
    end else begin
      res_vld_q <= 1'b0;
      if (avg_start) mean_q <= 32'sh0000_0000;
      unique case (state_q)
        ST_IDLE: if (accept) begin
          rdg_q <= RDG_VALUE;
          state_q <= ST_EXEC;
        end
        ST_EXEC: if (avg_on && count_q != 32'h0000_0000) begin
          rem_q <= '0;
          quo_q <= sum_q[SUM_W-1] ? SUM_W'(-sum_q) : SUM_W'(sum_q);
          dsr_q <= count_q;
          neg_q <= sum_q[SUM_W-1];
          step_q <= 8'(SUM_W);
          state_q <= ST_DIV;
        end else begin
          res_q <= '{value: math_val, sel: sel_q, math_on: en_q, lim_fail: lim_fail};
          res_vld_q <= 1'b1;
          state_q <= ST_IDLE;
        end
        ST_DIV: begin
          rem_q <= (rem_sh >= {1'b0, dsr_q}) ? rem_sh - {1'b0, dsr_q} : rem_sh;
          quo_q <= quo_nxt;
          step_q <= step_q - 8'h01;
          if (step_q == 8'h01) begin
            mean_q <= neg_q ? -32'(quo_nxt) : 32'(quo_nxt);
            res_q <= '{value: neg_q ? -32'(quo_nxt) : 32'(quo_nxt), sel: sel_q,
                       math_on: en_q, lim_fail: 1'b0};
            res_vld_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign RES_VALID = res_vld_q;
  assign RES = res_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  assign mean_err = longint'(sum_q) - longint'(mean_q) * longint'({1'b0, count_q});

  chk_count_clear: assert property (@(posedge CLK) disable iff (RESET)
    avg_start |=> count_q == 32'h0000_0000 && mean_q == 32'sh0000_0000)
    else $error("count or mean not cleared on averaging enable");
  chk_max_track: assert property (@(posedge CLK) disable iff (RESET)
    accept && avg_on && !avg_start && RDG_VALUE > max_q |=> max_q == $past(RDG_VALUE))
    else $error("maximum missed a larger reading");
  chk_min_track: assert property (@(posedge CLK) disable iff (RESET)
    accept && avg_on && !avg_start && count_q != 32'h0000_0000 && RDG_VALUE >= min_q
    |=> min_q == $past(min_q))
    else $error("minimum moved on a larger reading");
  chk_mean_value: assert property (@(posedge CLK) disable iff (RESET)
    $changed(mean_q) && count_q != 32'h0000_0000 && !$past(avg_start)
    |-> mean_err < longint'({1'b0, count_q}) && -mean_err < longint'({1'b0, count_q}))
    else $error("mean differs from sum over count");
  chk_ohm_legal: assert property (@(posedge CLK) disable iff (NV_INIT)
    rmp_pkg::ohms_ok(ohm_q))
    else $error("reference resistance outside the list");
  chk_sel_legal: assert property (@(posedge CLK) disable iff (RESET)
    sel_q inside {rmp_pkg::SEL_AVER, rmp_pkg::SEL_DB, rmp_pkg::SEL_DBM,
                  rmp_pkg::SEL_LIM, rmp_pkg::SEL_NULL})
    else $error("selection holds no operation");
  chk_math_gate: assert property (@(posedge CLK) disable iff (RESET)
    RES_VALID && !RES.math_on |-> RES.value == rdg_q && !RES.lim_fail)
    else $error("math applied while disabled");
  chk_null_out: assert property (@(posedge CLK) disable iff (RESET)
    state_q == ST_EXEC && en_q && sel_q == rmp_pkg::SEL_NULL
    |=> RES_VALID && RES.value == $past(rdg_q) - $past(null_q))
    else $error("null result wrong");
  chk_limit_flag: assert property (@(posedge CLK) disable iff (RESET)
    state_q == ST_EXEC && en_q && sel_q == rmp_pkg::SEL_LIM
    |=> RES_VALID && RES.lim_fail == ($past(rdg_q) < $past(lim_lo_q) ||
                                      $past(rdg_q) > $past(lim_hi_q)))
    else $error("limit verdict wrong");
  chk_conflict_off: assert property (@(posedge CLK) disable iff (RESET)
    en_q && MEAS_FUNC != fn_q && !rmp_pkg::allowed(sel_q, MEAS_FUNC)
    |=> !en_q && conflict_q)
    else $error("conflict did not turn math off");
  chk_result_lat: assert property (@(posedge CLK) disable iff (RESET)
    accept |=> !RES_VALID && !accept ##[1:RES_LAT_MAX] RES_VALID)
    else $error("no result for accepted reading");

  cov_avg_result: cover property (@(posedge CLK) disable iff (RESET)
    RES_VALID && RES.math_on && RES.sel == rmp_pkg::SEL_AVER);
  cov_db_result: cover property (@(posedge CLK) disable iff (RESET)
    RES_VALID && RES.math_on && RES.sel == rmp_pkg::SEL_DB);
  cov_lim_fail: cover property (@(posedge CLK) disable iff (RESET)
    RES_VALID && RES.lim_fail);
  cov_conflict: cover property (@(posedge CLK) disable iff (RESET) $rose(conflict_q));

endmodule : rmp_math_post

// file: tb/rmp_host.sv
// Host model: APB master that issues the register commands
module rmp_host (
  // Bus answer
  input wire logic clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Bus request
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [7:0] paddr = 8'h00,
  output logic [31:0] pwdata = 32'h0000_0000
);
  timeunit 1ns;
  timeprecision 1ps;

  // Request held until pready is seen high; only the bench timeout ends a wait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : rmp_host

// file: tb/tb_top.sv
// Self-checking testbench of the reading math post-processor
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic nv_init = 1'b1;
  logic rdg_valid = 1'b0;
  logic [31:0] rdg_value = 32'h0000_0000;
  logic [31:0] range_max = 32'h000A_0000;
  rmp_pkg::rmp_func_t meas_func = rmp_pkg::FN_DCV;
  logic psel, penable, pwrite, pready, pslverr, rdg_ready, res_valid, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  rmp_pkg::rmp_res_t res;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;

  always #20 clk = ~clk;

  rmp_math_post #(.SUM_W(48)) rmp_math_post_inst (.CLK(clk), .RESET(reset),
    .NV_INIT(nv_init), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .MEAS_FUNC(meas_func), .RANGE_MAX(range_max), .RDG_VALID(rdg_valid),
    .RDG_VALUE(rdg_value), .RDG_READY(rdg_ready), .RES_VALID(res_valid), .RES(res));
  rmp_host rmp_host_inst (.clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // Whole run needs well under two thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // Decibel results carry the log approximation: half a decibel either way
  task automatic chk_near(input string nm, input logic [31:0] ex, input logic [31:0] got);
    int d;
    d = int'(got) - int'(ex);
    n_compared++;
    if ($isunknown(got) || d > 128 || d < -128) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk_near
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    rmp_host_inst.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] ex);
    rmp_host_inst.xfer(1'b0, a, 32'h0000_0000, q, e);
    chk(nm, ex, q);
  endtask : rc
  task automatic rdg(input logic [31:0] v);
    @(posedge clk);
    rdg_valid <= 1'b1;
    rdg_value <= v;
    do @(posedge clk); while (rdg_ready !== 1'b1);
    rdg_valid <= 1'b0;
    do @(posedge clk); while (res_valid !== 1'b1);
  endtask : rdg

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_select;
    rc("ctrl", rmp_pkg::A_CTRL, 32'h0000_0040);
    rc("ohms", rmp_pkg::A_DBM_REF, 32'h0000_0258);
    rmp_host_inst.xfer(1'b0, 8'h34, 32'h0000_0000, q, e);
    chk("slverr", 32'h0000_0001, {31'h0, e});
    for (int i = 0; i < 5; i++) begin
      wr(rmp_pkg::A_CTRL, 32'(i) << 4);
      rc("sel", rmp_pkg::A_CTRL, 32'(i) << 4);
    end
    wr(rmp_pkg::A_CTRL, 32'h0000_0041);
    rc("en", rmp_pkg::A_CTRL, 32'h0000_0041);
  endtask : t_select

  task automatic t_null;
    wr(rmp_pkg::A_NULL, 32'h0001_0000);
    wr(rmp_pkg::A_NULL, 32'h7FFF_0000);
    rc("null", rmp_pkg::A_NULL, 32'h0001_0000);
    wr(rmp_pkg::A_DB_REF, 32'h0000_C800);
    wr(rmp_pkg::A_DB_REF, 32'h0000_C801);
    rc("dbref", rmp_pkg::A_DB_REF, 32'h0000_C800);
    rdg(32'h0005_0000);
    chk("nres", 32'h0004_0000, res.value);
    chk("nflag", 32'h0000_0009, {28'h0, res.sel, res.math_on});
    wr(rmp_pkg::A_CTRL, 32'h0000_0040);
    rdg(32'h0005_0000);
    chk("off", 32'h0000_0008, {28'h0, res.sel, res.math_on});
    chk("offv", 32'h0005_0000, res.value);
  endtask : t_null

  task automatic t_limit;
    wr(rmp_pkg::A_CTRL, 32'h0000_0031);
    wr(rmp_pkg::A_LIM_LO, 32'h0001_0000);
    wr(rmp_pkg::A_LIM_HI, 32'h0003_0000);
    rdg(32'h0003_0000);
    chk("pass", 32'h0000_0000, {31'h0, res.lim_fail});
    rdg(32'h0003_0001);
    chk("fail", 32'h0000_0001, {31'h0, res.lim_fail});
    rc("sts", rmp_pkg::A_STATUS, 32'h0000_0006);
    range_max <= 32'h0001_0000;
    wr(rmp_pkg::A_PRESET, 32'h0000_0009);
    rc("lomin", rmp_pkg::A_LIM_LO, 32'hFFFE_CCCD);
    rc("himax", rmp_pkg::A_LIM_HI, 32'h0001_3333);
    range_max <= 32'h000A_0000;
  endtask : t_limit

  // One volt into one kilohm is one milliwatt, so 0 dBm
  task automatic t_decibel;
    wr(rmp_pkg::A_CTRL, 32'h0000_0021);
    wr(rmp_pkg::A_DBM_REF, 32'h0000_03E8);
    wr(rmp_pkg::A_DB_REF, 32'h0000_0A00);
    rdg(32'h0001_0000);
    chk_near("dbm", 32'h0000_0000, res.value);
    wr(rmp_pkg::A_CTRL, 32'h0000_0011);
    rdg(32'h0001_0000);
    chk_near("db", 32'hFFFF_F600, res.value);
  endtask : t_decibel

  task automatic t_aver;
    wr(rmp_pkg::A_CTRL, 32'h0000_0001);
    rdg(32'h0004_0000);
    rdg(32'h0002_0000);
    rdg(32'h0006_0000);
    rc("count", rmp_pkg::A_COUNT, 32'h0000_0003);
    rc("max", rmp_pkg::A_MAX, 32'h0006_0000);
    rc("min", rmp_pkg::A_MIN, 32'h0002_0000);
    rc("mean", rmp_pkg::A_MEAN, 32'h0004_0000);
    wr(rmp_pkg::A_CTRL, 32'h0000_0000);
    wr(rmp_pkg::A_CTRL, 32'h0000_0001);
    rc("recount", rmp_pkg::A_COUNT, 32'h0000_0000);
    rc("remean", rmp_pkg::A_MEAN, 32'h0000_0000);
    rc("remax", rmp_pkg::A_MAX, 32'h0000_0000);
  endtask : t_aver

  task automatic t_ohms_reset;
    wr(rmp_pkg::A_DBM_REF, 32'h0000_0087);
    wr(rmp_pkg::A_DBM_REF, 32'h0000_0088);
    rc("list", rmp_pkg::A_DBM_REF, 32'h0000_0087);
    wr(rmp_pkg::A_PRESET, 32'h0000_0200);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rc("keep", rmp_pkg::A_DBM_REF, 32'h0000_1F40);
    rc("vol", rmp_pkg::A_LIM_HI, 32'h0000_0000);
    rc("ctrl0", rmp_pkg::A_CTRL, 32'h0000_0040);
    meas_func <= rmp_pkg::FN_DCI;
    wr(rmp_pkg::A_CTRL, 32'h0000_0011);
    rc("refuse", rmp_pkg::A_CTRL, 32'h0000_0010);
    wr(rmp_pkg::A_CTRL, 32'h0000_0041);
    wr(rmp_pkg::A_CTRL, 32'h0000_0011);
    rc("confl", rmp_pkg::A_STATUS, 32'h0000_0001);
    wr(rmp_pkg::A_STATUS, 32'h0000_0001);
    rc("clr", rmp_pkg::A_STATUS, 32'h0000_0000);
    meas_func <= rmp_pkg::FN_DCV;
    wr(rmp_pkg::A_CTRL, 32'h0000_0011);
    meas_func <= rmp_pkg::FN_DCI;
    rc("drop", rmp_pkg::A_CTRL, 32'h0000_0010);
    rc("confl2", rmp_pkg::A_STATUS, 32'h0000_0001);
  endtask : t_ohms_reset

  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    nv_init <= 1'b0;
    t_select();
    t_null();
    t_limit();
    t_decibel();
    t_aver();
    t_ohms_reset();
    complete_run();
  end
endmodule : tb_top
